// [include/prsc_map.svh]
// constants for the pad reset state control block
// What this block does
// - reset forces fixed pad states, ignores software
// - power-on phase: every pad fully tristate
// - after power-on: tristate except listed pads
// - flash boot strap pulled down; sampled
// - alternate boot strap pulled up after power-on
// - reset pad low, pull-up after second phase
// - test clock/mode/data-in pulled up; data-out tristate
// - analog converter pads never drive
// - oscillator pads stay tristate during reset
`ifndef PRSC_MAP_SVH
`define PRSC_MAP_SVH

`define PRSC_NUM_PADS        32
`define PRSC_IDX_FLASH_BOOT  9
`define PRSC_IDX_ALT_BOOT    8
`define PRSC_IDX_RESET_PAD   16
`define PRSC_IDX_OSC_IN      17
`define PRSC_IDX_OSC_OUT     18
`define PRSC_IDX_TCK         19
`define PRSC_IDX_TMS         20
`define PRSC_IDX_TDI         21
`define PRSC_IDX_TDO         22
`define PRSC_ANALOG_MASK     32'h0000_00F0

`define PRSC_MODE_Z          3'h0
`define PRSC_MODE_PD         3'h1
`define PRSC_MODE_PU         3'h2
`define PRSC_MODE_DRV0       3'h3
`define PRSC_MODE_SW         3'h4

`define PRSC_PH_POR          2'h0
`define PRSC_PH_EARLY        2'h1
`define PRSC_PH_LATE         2'h3
`define PRSC_PH_RUN          2'h2

`endif

// [include/prsc_pkg.sv]
// types shared by the pad reset state control block
`include "prsc_map.svh"
package prsc_pkg;
  typedef enum logic [1:0] {
    PRSC_POR   = `PRSC_PH_POR,
    PRSC_EARLY = `PRSC_PH_EARLY,
    PRSC_LATE  = `PRSC_PH_LATE,
    PRSC_RUN   = `PRSC_PH_RUN
  } prsc_phase_type;

  typedef enum logic [2:0] {
    PRSC_M_Z    = `PRSC_MODE_Z,
    PRSC_M_PD   = `PRSC_MODE_PD,
    PRSC_M_PU   = `PRSC_MODE_PU,
    PRSC_M_DRV0 = `PRSC_MODE_DRV0,
    PRSC_M_SW   = `PRSC_MODE_SW
  } prsc_mode_type;
endpackage

// [core/prsc_pad_cell.sv]
// one pad: turns a forced mode or the software setting into driver and pull controls
`timescale 1ns/100ps
module prsc_pad_cell
  import prsc_pkg::*;
(
  input  prsc_mode_type mode,
  input  wire logic     analog,
  input  wire logic     sw_oe,
  input  wire logic     sw_out,
  input  wire logic     sw_pull_up,
  input  wire logic     sw_pull_down,
  output logic          oe,
  output logic          out,
  output logic          pull_up,
  output logic          pull_down
);
  always_comb begin
    oe        = 1'b0;
    out       = 1'b0;
    pull_up   = 1'b0;
    pull_down = 1'b0;
    case (mode)
      PRSC_M_Z: begin
        oe = 1'b0;
      end
      PRSC_M_PD: begin
        pull_down = 1'b1;
      end
      PRSC_M_PU: begin
        pull_up = 1'b1;
      end
      PRSC_M_DRV0: begin
        oe  = 1'b1;
        out = 1'b0;
      end
      PRSC_M_SW: begin
        oe        = sw_oe & ~analog;
        out       = sw_out;
        // both pulls at once would fight; pull-up wins
        pull_up   = sw_pull_up;
        pull_down = sw_pull_down & ~sw_pull_up;
      end
      default: begin
        oe = 1'b0;
      end
    endcase
    if (analog) begin
      oe = 1'b0;
    end
  end
endmodule

// [core/prsc_top.sv]
// pad state sequencing through the reset phases, with boot strap capture
`timescale 1ns/100ps
`include "prsc_map.svh"
module prsc_top
  import prsc_pkg::*;
#(
  parameter int                    NUM_PADS       = `PRSC_NUM_PADS,
  parameter int                    IDX_FLASH_BOOT = `PRSC_IDX_FLASH_BOOT,
  parameter int                    IDX_ALT_BOOT   = `PRSC_IDX_ALT_BOOT,
  parameter int                    IDX_RESET_PAD  = `PRSC_IDX_RESET_PAD,
  parameter int                    IDX_OSC_IN     = `PRSC_IDX_OSC_IN,
  parameter int                    IDX_OSC_OUT    = `PRSC_IDX_OSC_OUT,
  parameter int                    IDX_TCK        = `PRSC_IDX_TCK,
  parameter int                    IDX_TMS        = `PRSC_IDX_TMS,
  parameter int                    IDX_TDI        = `PRSC_IDX_TDI,
  parameter int                    IDX_TDO        = `PRSC_IDX_TDO,
  parameter logic [NUM_PADS-1:0]   ANALOG_MASK    = NUM_PADS'(`PRSC_ANALOG_MASK)
)
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                power_on_phase,
  input  wire logic                reset_active,
  input  wire logic                second_reset_phase_done,
  input  wire logic [NUM_PADS-1:0] pad_in,
  input  wire logic [NUM_PADS-1:0] sw_oe,
  input  wire logic [NUM_PADS-1:0] sw_out,
  input  wire logic [NUM_PADS-1:0] sw_pull_up,
  input  wire logic [NUM_PADS-1:0] sw_pull_down,
  output logic [NUM_PADS-1:0]      pad_oe,
  output logic [NUM_PADS-1:0]      pad_out,
  output logic [NUM_PADS-1:0]      pad_pull_up,
  output logic [NUM_PADS-1:0]      pad_pull_down,
  output logic                     boot_from_flash,
  output logic                     alternate_boot_select,
  output logic                     sw_control_active
);

  // an index outside the vector, or one pad given two roles, would
  // silently lose a forced reset state, so such parameters are refused
  if (NUM_PADS < 1) begin : g_chk_num_pads
    $error("prsc_top: the pad vector must hold at least one pad");
  end
  if (IDX_FLASH_BOOT < 0 || IDX_FLASH_BOOT >= NUM_PADS) begin : g_chk_flash_boot
    $error("prsc_top: flash boot strap index outside the pad vector");
  end
  if (IDX_ALT_BOOT < 0 || IDX_ALT_BOOT >= NUM_PADS) begin : g_chk_alt_boot
    $error("prsc_top: alternate boot strap index outside the pad vector");
  end
  if (IDX_RESET_PAD < 0 || IDX_RESET_PAD >= NUM_PADS) begin : g_chk_reset_pad
    $error("prsc_top: reset pad index outside the pad vector");
  end
  if (IDX_OSC_IN < 0 || IDX_OSC_IN >= NUM_PADS) begin : g_chk_osc_in
    $error("prsc_top: oscillator input index outside the pad vector");
  end
  if (IDX_OSC_OUT < 0 || IDX_OSC_OUT >= NUM_PADS) begin : g_chk_osc_out
    $error("prsc_top: oscillator output index outside the pad vector");
  end
  if (IDX_TCK < 0 || IDX_TCK >= NUM_PADS) begin : g_chk_tck
    $error("prsc_top: test clock index outside the pad vector");
  end
  if (IDX_TMS < 0 || IDX_TMS >= NUM_PADS) begin : g_chk_tms
    $error("prsc_top: test mode index outside the pad vector");
  end
  if (IDX_TDI < 0 || IDX_TDI >= NUM_PADS) begin : g_chk_tdi
    $error("prsc_top: test data in index outside the pad vector");
  end
  if (IDX_TDO < 0 || IDX_TDO >= NUM_PADS) begin : g_chk_tdo
    $error("prsc_top: test data out index outside the pad vector");
  end

  // the mode decode takes the first role that matches, so roles must not share a pad
  localparam int NUM_ROLES = 9;
  localparam int ROLE_IDX [NUM_ROLES] = '{
    IDX_FLASH_BOOT,
    IDX_ALT_BOOT,
    IDX_RESET_PAD,
    IDX_OSC_IN,
    IDX_OSC_OUT,
    IDX_TCK,
    IDX_TMS,
    IDX_TDI,
    IDX_TDO
  };
  for (genvar a = 0; a < NUM_ROLES; a++) begin : g_chk_role
    for (genvar b = a + 1; b < NUM_ROLES; b++) begin : g_chk_pair
      if (ROLE_IDX[a] == ROLE_IDX[b]) begin : g_dup
        $error("prsc_top: two pad roles share one pad index");
      end
    end
  end

  // the reset pad must drive low, which an analog pad never can
  if (IDX_RESET_PAD < NUM_PADS && ANALOG_MASK[IDX_RESET_PAD]) begin : g_chk_reset_analog
    $error("prsc_top: the reset pad is marked analog");
  end

  typedef struct packed {
    prsc_phase_type      phase;
    logic [NUM_PADS-1:0] oe;
    logic [NUM_PADS-1:0] out;
    logic [NUM_PADS-1:0] pull_up;
    logic [NUM_PADS-1:0] pull_down;
    logic                boot_from_flash;
    logic                alternate_boot_select;
    logic                sw_control_active;
  } prsc_state_type;

  prsc_state_type      cur;
  prsc_state_type      next_cur;
  prsc_phase_type      next_phase;
  prsc_mode_type       mode     [NUM_PADS];
  logic [NUM_PADS-1:0] cell_oe;
  logic [NUM_PADS-1:0] cell_out;
  logic [NUM_PADS-1:0] cell_pu;
  logic [NUM_PADS-1:0] cell_pd;

  // phase follows the reset generator; power-on overrides everything
  always_comb begin
    next_phase = cur.phase;
    case (cur.phase)
      PRSC_POR, PRSC_EARLY, PRSC_LATE, PRSC_RUN: begin
        if (power_on_phase) begin
          next_phase = PRSC_POR;
        end else if (!reset_active) begin
          next_phase = PRSC_RUN;
        end else if (second_reset_phase_done) begin
          next_phase = PRSC_LATE;
        end else if (cur.phase == PRSC_LATE) begin
          // a later reset that skips power-on restarts the early phase
          next_phase = PRSC_EARLY;
        end else begin
          next_phase = PRSC_EARLY;
        end
      end
      default: begin
        next_phase = PRSC_POR;
      end
    endcase
  end

  // forced mode per pad for the phase being entered
  always_comb begin
    for (int i = 0; i < NUM_PADS; i++) begin
      mode[i] = PRSC_M_Z;
      case (next_phase)
        PRSC_POR: begin
          mode[i] = PRSC_M_Z;
        end
        PRSC_EARLY, PRSC_LATE: begin
          if (i == IDX_FLASH_BOOT) begin
            mode[i] = PRSC_M_PD;
          end else if (i == IDX_ALT_BOOT) begin
            mode[i] = PRSC_M_PU;
          end else if (i == IDX_RESET_PAD) begin
            mode[i] = (next_phase == PRSC_LATE) ? PRSC_M_PU : PRSC_M_DRV0;
          end else if (i == IDX_TCK || i == IDX_TMS || i == IDX_TDI) begin
            mode[i] = PRSC_M_PU;
          end else if (i == IDX_TDO || i == IDX_OSC_IN || i == IDX_OSC_OUT) begin
            mode[i] = PRSC_M_Z;
          end else begin
            mode[i] = PRSC_M_Z;
          end
        end
        PRSC_RUN: begin
          mode[i] = PRSC_M_SW;
        end
        default: begin
          mode[i] = PRSC_M_Z;
        end
      endcase
    end
  end

  // software settings reach a pad only through the SW mode
  for (genvar g = 0; g < NUM_PADS; g++) begin : g_pad
    prsc_pad_cell u_cell (
      .mode         (mode[g]),
      .analog       (ANALOG_MASK[g]),
      .sw_oe        (sw_oe[g]),
      .sw_out       (sw_out[g]),
      .sw_pull_up   (sw_pull_up[g]),
      .sw_pull_down (sw_pull_down[g]),
      .oe           (cell_oe[g]),
      .out          (cell_out[g]),
      .pull_up      (cell_pu[g]),
      .pull_down    (cell_pd[g])
    );
  end

  always_comb begin
    next_cur           = cur;
    next_cur.phase     = next_phase;
    next_cur.oe        = cell_oe;
    next_cur.out       = cell_out;
    next_cur.pull_up   = cell_pu;
    next_cur.pull_down = cell_pd;
    next_cur.sw_control_active = (next_phase == PRSC_RUN);
    // straps sampled while still pulled, on the cycle reset is released
    if (cur.phase != PRSC_RUN && cur.phase != PRSC_POR && next_phase == PRSC_RUN) begin
      next_cur.boot_from_flash       = ~pad_in[IDX_FLASH_BOOT];
      next_cur.alternate_boot_select = pad_in[IDX_ALT_BOOT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '{phase: PRSC_POR, boot_from_flash: 1'b1, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign pad_oe                = cur.oe;
  assign pad_out               = cur.out;
  assign pad_pull_up           = cur.pull_up;
  assign pad_pull_down         = cur.pull_down;
  assign boot_from_flash       = cur.boot_from_flash;
  assign alternate_boot_select = cur.alternate_boot_select;
  assign sw_control_active     = cur.sw_control_active;

endmodule

// [verif/prsc_properties.sv]
// assertions on the pad reset state control ports
`timescale 1ns/100ps
module prsc_properties #(
  parameter int NUM_PADS = 32
)
(
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                power_on_phase,
  input wire logic                reset_active,
  input wire logic                second_reset_phase_done,
  input wire logic [NUM_PADS-1:0] sw_out,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic [NUM_PADS-1:0] pad_out,
  input wire logic [NUM_PADS-1:0] pad_pull_up,
  input wire logic [NUM_PADS-1:0] pad_pull_down,
  input wire logic                sw_control_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire early = !power_on_phase && reset_active;
  por_tristate_a: assert property (power_on_phase |=>
    !(|{pad_oe, pad_pull_up, pad_pull_down})) else $error("pad not tristate");
  analog_no_drive_a: assert property (pad_oe[7:4] == 4'h0) else $error("analog driven");
  reset_pad_low_a: assert property (early && !second_reset_phase_done |=>
    pad_oe[16] && !pad_out[16]) else $error("reset pad not low");
  reset_pad_pu_a: assert property (early && second_reset_phase_done |=>
    !pad_oe[16] && pad_pull_up[16]) else $error("reset pad not pulled up");
  flash_strap_pd_a: assert property (early |=>
    pad_pull_down[9] && !pad_pull_up[9]) else $error("flash strap pull");
  alt_strap_pu_a: assert property (early |=> pad_pull_up[8]) else $error("alt strap pull");
  test_port_pu_a: assert property (early |=>
    pad_pull_up[22:19] == 4'h7 && !pad_oe[22]) else $error("test port pulls");
  osc_tristate_a: assert property (reset_active |=>
    !(|{pad_oe[18:17], pad_pull_up[18:17]})) else $error("osc pad not tristate");
  others_tristate_a: assert property (early |=> !sw_control_active &&
    (pad_oe & ~NUM_PADS'(32'h0001_0000)) == '0) else $error("extra pad driven");
  sw_handover_a: assert property (!reset_active && !power_on_phase |=>
    sw_control_active && pad_out == $past(sw_out)) else $error("no handover");
endmodule
bind prsc_top prsc_properties #(.NUM_PADS(NUM_PADS)) u_prsc_properties (.clk, .resetn,
  .power_on_phase, .reset_active, .second_reset_phase_done, .sw_out, .pad_oe, .pad_out,
  .pad_pull_up, .pad_pull_down, .sw_control_active);

// [verif/prsc_board.sv]
// board side: boot straps and loose pad levels seen at the pad inputs
`timescale 1ns/100ps
module prsc_board (
  input  wire logic        clk,
  input  wire logic [31:0] pad_pull_down,
  input  wire logic [31:0] pad_pull_up,
  input  wire logic        flash_strong_pu,
  input  wire logic        alt_tie_low,
  output logic      [31:0] pad_in
);
  logic [31:0] float_level = 32'h5555_5555;
  // nothing holds a loose pad, so it never repeats its last level
  always @(posedge clk) float_level <= ~float_level;
  always_comb begin
    pad_in = float_level;
    // a strong board pull-up beats the internal pull-down
    pad_in[9] = flash_strong_pu | pad_pull_up[9] | (!pad_pull_down[9] & float_level[9]);
    pad_in[8] = !alt_tie_low & (pad_pull_up[8] | float_level[8]);
  end
endmodule

// [verif/tb_pad_reset_state_control.sv]
// self-checking bench for the pad reset state control block
`timescale 1ns/100ps
module tb_pad_reset_state_control;
  logic clk = 1'b0, resetn = 1'b0, power_on_phase = 1'b1, reset_active = 1'b1;
  logic second_reset_phase_done = 1'b0, flash_pu = 1'b0, alt_low = 1'b0;
  logic [31:0] sw_oe = '0, sw_out = '0, sw_pull_up = '0, sw_pull_down = '0, pad_in;
  logic [31:0] pad_oe, pad_out, pad_pull_up, pad_pull_down;
  logic boot_from_flash, alternate_boot_select, sw_control_active;
  int bad_count = 0, tests_run = 0;
  prsc_top u_prsc_top (.clk, .resetn, .power_on_phase, .reset_active,
    .second_reset_phase_done, .pad_in, .sw_oe, .sw_out, .sw_pull_up, .sw_pull_down,
    .pad_oe, .pad_out, .pad_pull_up, .pad_pull_down, .boot_from_flash,
    .alternate_boot_select, .sw_control_active);
  prsc_board u_prsc_board (.clk, .pad_pull_down, .pad_pull_up, .flash_strong_pu(flash_pu),
    .alt_tie_low(alt_low), .pad_in);
  initial forever #4 clk = ~clk;
  task check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // phase 0 power-on, 1 early, 2 late, 3 run
  function logic [127:0] exp_pads(input int p);
    case (p)
      0: exp_pads = '0;
      1: exp_pads = {32'h0001_0000, 32'h0000_0000, 32'h0038_0100, 32'h0000_0200};
      2: exp_pads = {32'h0000_0000, 32'h0000_0000, 32'h0039_0100, 32'h0000_0200};
      default: exp_pads = {sw_oe & ~32'h0000_00F0, sw_out, sw_pull_up,
                           sw_pull_down & ~sw_pull_up};
    endcase
  endfunction
  task step(input int p, input logic [31:0] fill);
    @(posedge clk);
    power_on_phase <= (p == 0);
    reset_active <= (p != 3);
    second_reset_phase_done <= (p == 2);
    sw_oe <= fill | $urandom;
    sw_out <= fill | $urandom;
    sw_pull_up <= fill | $urandom;
    sw_pull_down <= fill | $urandom;
    @(posedge clk);
    @(negedge clk);
    check({pad_oe, pad_out, pad_pull_up, pad_pull_down}, exp_pads(p));
    check(128'(sw_control_active), 128'(p == 3));
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    logic [31:0] fill;
    void'($urandom(47774));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      flash_pu <= i[0];
      alt_low <= i[1];
      // first pass asks for every driver and both pulls at once
      fill = (i == 0) ? '1 : '0;
      step(0, fill);
      step(3, fill);
      step(1, fill);
      step(2, fill);
      step(3, fill);
      check(128'({boot_from_flash, alternate_boot_select}), 128'({!flash_pu, !alt_low}));
      step(1, fill);
      step(3, fill);
      check(128'({boot_from_flash, alternate_boot_select}), 128'({!flash_pu, !alt_low}));
      $display("test %0d finished", i);
    end
    // reset in mid-run, then a release straight into run: straps keep reset values
    @(posedge clk);
    resetn <= 1'b0;
    @(negedge clk);
    check({pad_oe, pad_out, pad_pull_up, pad_pull_down}, exp_pads(0));
    check(128'({boot_from_flash, alternate_boot_select, sw_control_active}), 128'(3'h4));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    step(3, '0);
    check(128'({boot_from_flash, alternate_boot_select}), 128'(2'h2));
    $display("test mid-run reset finished");
    end_of_test;
  end
  initial begin
    #(8 * 500);
    bad_count++;
    end_of_test;
  end
endmodule
